// ==== lacfg_field.sv ====
// one read/write configuration field with its own reset value
`timescale 1ns/1ps
module lacfg_field #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic sys_clk,
	input wire logic nrst,
	lacfg_field_if.store fld
);

	logic [W-1:0] val_r; // held field value

	// load on the write pulse, default on reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			val_r <= RST;
		end else if (fld.wr_en) begin
			val_r <= fld.wr_data;
		end
	end

	assign fld.q = val_r;

endmodule

// ==== lacfg_field_if.sv ====
// interface between the bus decoder and one stored configuration field
`timescale 1ns/1ps
interface lacfg_field_if #(
	parameter int W = 1
);
	logic wr_en; // one-cycle load pulse from the decoder
	logic [W-1:0] wr_data; // value to load
	logic [W-1:0] q; // stored field value

	// decoder side drives loads and reads the value back
	modport ctrl (
		output wr_en,
		output wr_data,
		input q
	);

	// storage side keeps the value
	modport store (
		input wr_en,
		input wr_data,
		output q
	);
endinterface

// ==== lacfg_pkg.sv ====
// package of offsets, field layouts and reset values for the loop zero configuration bank
package lacfg_pkg;

	// register bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	typedef logic [ADDR_W-1:0] lacfg_addr_t;
	typedef logic [DATA_W-1:0] lacfg_data_t;

	// register offsets, byte addressed as printed
	localparam lacfg_addr_t OFF_PUMP_FILTER = 8'hac;
	localparam lacfg_addr_t OFF_MODE_LOCK = 8'had;
	localparam lacfg_addr_t OFF_OSC_SEL_CODE1 = 8'hae;
	localparam lacfg_addr_t OFF_OSC_CODE2 = 8'haf;

	// field widths
	localparam int PUMP_W = 3;
	localparam int RES_W = 2;
	localparam int CAP_W = 2;
	localparam int CODE_W = 5;

	// field positions (lsb) inside their registers
	localparam int POS_PUMP = 5;
	localparam int POS_RES = 3;
	localparam int POS_CAP = 1;
	localparam int POS_POLE = 0;
	localparam int POS_SYNTH = 3;
	localparam int POS_LOCK_ACC = 1;
	localparam int POS_OVERRIDE = 0;
	localparam int POS_OSC_SEL = 5;
	localparam int POS_CODE_A = 0;
	localparam int POS_CODE_B = 0;

	// reset values of the fields
	localparam logic [PUMP_W-1:0] RST_PUMP = 3'h4;
	localparam logic [RES_W-1:0] RST_RES = 2'h1;
	localparam logic [CAP_W-1:0] RST_CAP = 2'h1;
	localparam logic RST_POLE = 1'h1;
	localparam logic RST_LOCK_ACC = 1'h1;
	localparam logic RST_OVERRIDE = 1'h0;
	localparam logic RST_OSC_SEL = 1'h1;
	localparam logic [CODE_W-1:0] RST_CODE_A = 5'h0b;
	localparam logic [CODE_W-1:0] RST_CODE_B = 5'h00;
	localparam logic RST_SYNTH = 1'h0;

	// decoded analog figures
	localparam int PUMP_UA_W = 10;
	localparam logic [PUMP_UA_W-1:0] PUMP_STEP_UA = 10'h06e;
	localparam int CAP_PF_W = 8;
	localparam logic [CAP_PF_W-1:0] CAP_PF_C0 = 8'h28;
	localparam logic [CAP_PF_W-1:0] CAP_PF_C1 = 8'h50;
	localparam logic [CAP_PF_W-1:0] CAP_PF_C2 = 8'h8c;
	localparam logic [CAP_PF_W-1:0] CAP_PF_C3 = 8'hc8;

endpackage

// ==== lacfg_regs.sv ====
// configuration register bank for analog loop zero
`timescale 1ns/1ps

// Function
// [R1] pump current 110 uA steps, reset 100
// [R2] series resistor select two bits, reset 01
// [R3] parallel capacitor select two bits, reset 01
// [R4] second pole select bit, reset 1
// [R5] lock count accuracy 1 or 16 ppm
// [R6] software clears accuracy bit above 95 nF
// [R7] lock override automatic or manual, reset 0
// [R8] manual oscillator select, reset 1
// [R9] oscillator a manual lock code, reset 01011
// [R10] oscillator b manual lock code, reset 00000
// [R11] synthesizer mode bit, reset 0
// [R12] software forces freerun when selecting synthesis
// [R13] reserved bits written zero, read undefined
// [R14] reset defaults, readback, immediate effect
module lacfg_regs (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [lacfg_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [lacfg_pkg::DATA_W-1:0] reg_wr_data,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	output logic [lacfg_pkg::DATA_W-1:0] reg_rd_data,
	output logic [lacfg_pkg::PUMP_W-1:0] pump_current_sel,
	output logic [lacfg_pkg::RES_W-1:0] filter_series_res_sel,
	output logic [lacfg_pkg::CAP_W-1:0] filter_parallel_cap_sel,
	output logic second_pole_sel,
	output logic lock_count_accuracy,
	output logic lock_manual_override,
	output logic manual_osc_select,
	output logic [lacfg_pkg::CODE_W-1:0] manual_lock_code_osc_a,
	output logic [lacfg_pkg::CODE_W-1:0] manual_lock_code_osc_b,
	output logic synth_only_mode,
	output logic [lacfg_pkg::PUMP_UA_W-1:0] pump_current_ua,
	output logic [lacfg_pkg::CAP_PF_W-1:0] filter_cap_pf,
	output logic [lacfg_pkg::CODE_W-1:0] manual_lock_code_applied,
	output logic manual_lock_active
);

	// software sees four byte registers at consecutive offsets; a write lands in one strobe cycle
	// and a read answers from a register in the next cycle, so the bus never waits on this bank
	// there is no shadow copy or commit strobe: a field reaches the analog loop the cycle after
	// its write, so a filter change takes effect mid-lock; software owns the sequencing of that
	// trade-off: no double buffering keeps the bank small, at the cost of non-atomic multi-register updates
	// the decoded outputs below are conveniences for the loop and lag their fields by one cycle

	// address decode of the four registers
	logic hit_pump_filter; // write to pump and filter register
	logic hit_mode_lock; // write to mode and lock register
	logic hit_osc_code1; // write to oscillator select and code a register
	logic hit_osc_code2; // write to code b register

	// full eight-bit compare, so no alias of the four offsets can load a field
	// a read strobe never reaches these, so reads have no side effects
	// writes to any other offset fall through all four compares and are dropped
	assign hit_pump_filter = reg_wr_en && (reg_addr == lacfg_pkg::OFF_PUMP_FILTER);
	assign hit_mode_lock = reg_wr_en && (reg_addr == lacfg_pkg::OFF_MODE_LOCK);
	assign hit_osc_code1 = reg_wr_en && (reg_addr == lacfg_pkg::OFF_OSC_SEL_CODE1);
	assign hit_osc_code2 = reg_wr_en && (reg_addr == lacfg_pkg::OFF_OSC_CODE2);

	// one carrier per stored field
	// each carrier is sized to its field, so widths are checked where the field is built
	// this module drives the load side; the storage side sits in the field instances
	lacfg_field_if #(.W(lacfg_pkg::PUMP_W)) pump_if ();
	lacfg_field_if #(.W(lacfg_pkg::RES_W)) res_if ();
	lacfg_field_if #(.W(lacfg_pkg::CAP_W)) cap_if ();
	lacfg_field_if #(.W(1)) pole_if ();
	lacfg_field_if #(.W(1)) acc_if ();
	lacfg_field_if #(.W(1)) ovr_if ();
	lacfg_field_if #(.W(1)) osc_if ();
	lacfg_field_if #(.W(lacfg_pkg::CODE_W)) code_a_if ();
	lacfg_field_if #(.W(lacfg_pkg::CODE_W)) code_b_if ();
	lacfg_field_if #(.W(1)) syn_if ();

	// write steering: each field slices its bits out of the write byte
	// reserved positions are simply not stored, so a nonzero write there is harmless
	// pump and filter byte: every field loads together, so software updates it as a whole byte
	// it holds pump current, series resistor, parallel capacitor and second pole
	assign pump_if.wr_en = hit_pump_filter; // [R1]
	assign pump_if.wr_data = reg_wr_data[lacfg_pkg::POS_PUMP +: lacfg_pkg::PUMP_W];
	assign res_if.wr_en = hit_pump_filter; // [R2]
	assign res_if.wr_data = reg_wr_data[lacfg_pkg::POS_RES +: lacfg_pkg::RES_W];
	assign cap_if.wr_en = hit_pump_filter; // [R3]
	assign cap_if.wr_data = reg_wr_data[lacfg_pkg::POS_CAP +: lacfg_pkg::CAP_W];
	assign pole_if.wr_en = hit_pump_filter; // [R4]
	assign pole_if.wr_data = reg_wr_data[lacfg_pkg::POS_POLE];
	// mode byte: bit 2 and the top four bits are reserved and dropped
	assign acc_if.wr_en = hit_mode_lock; // [R5]
	assign acc_if.wr_data = reg_wr_data[lacfg_pkg::POS_LOCK_ACC];
	assign ovr_if.wr_en = hit_mode_lock; // [R7]
	assign ovr_if.wr_data = reg_wr_data[lacfg_pkg::POS_OVERRIDE];
	assign syn_if.wr_en = hit_mode_lock; // [R11]
	assign syn_if.wr_data = reg_wr_data[lacfg_pkg::POS_SYNTH];
	// oscillator select and code a byte: the top two bits are reserved
	assign osc_if.wr_en = hit_osc_code1; // [R8]
	assign osc_if.wr_data = reg_wr_data[lacfg_pkg::POS_OSC_SEL];
	assign code_a_if.wr_en = hit_osc_code1; // [R9]
	assign code_a_if.wr_data = reg_wr_data[lacfg_pkg::POS_CODE_A +: lacfg_pkg::CODE_W];
	// code b byte: the top three bits are reserved
	assign code_b_if.wr_en = hit_osc_code2; // [R10]
	assign code_b_if.wr_data = reg_wr_data[lacfg_pkg::POS_CODE_B +: lacfg_pkg::CODE_W];

	// field storage, each with its own reset default
	// charge pump step code, reset to the fifth step
	lacfg_field #(.W(lacfg_pkg::PUMP_W), .RST(lacfg_pkg::RST_PUMP)) u_pump (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.fld(pump_if.store)
	);
	// series resistor code
	lacfg_field #(.W(lacfg_pkg::RES_W), .RST(lacfg_pkg::RST_RES)) u_res (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.fld(res_if.store)
	);
	// parallel capacitor code
	lacfg_field #(.W(lacfg_pkg::CAP_W), .RST(lacfg_pkg::RST_CAP)) u_cap (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.fld(cap_if.store)
	);
	// second pole bit, reset to the higher resistor
	lacfg_field #(.W(1), .RST(lacfg_pkg::RST_POLE)) u_pole (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.fld(pole_if.store)
	);
	// lock count accuracy, reset to the coarse setting
	lacfg_field #(.W(1), .RST(lacfg_pkg::RST_LOCK_ACC)) u_acc (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.fld(acc_if.store)
	);
	// manual override, reset to automatic handling
	lacfg_field #(.W(1), .RST(lacfg_pkg::RST_OVERRIDE)) u_ovr (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.fld(ovr_if.store)
	);
	// manual oscillator choice, reset to oscillator a
	lacfg_field #(.W(1), .RST(lacfg_pkg::RST_OSC_SEL)) u_osc (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.fld(osc_if.store)
	);
	// manual lock code for oscillator a
	lacfg_field #(.W(lacfg_pkg::CODE_W), .RST(lacfg_pkg::RST_CODE_A)) u_code_a (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.fld(code_a_if.store)
	);
	// manual lock code for oscillator b
	lacfg_field #(.W(lacfg_pkg::CODE_W), .RST(lacfg_pkg::RST_CODE_B)) u_code_b (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.fld(code_b_if.store)
	);
	// synthesis mode, reset to jitter attenuation
	lacfg_field #(.W(1), .RST(lacfg_pkg::RST_SYNTH)) u_syn (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.fld(syn_if.store)
	);

	// field values drive the analog loop straight from their flops, no commit step
	// no logic sits between a storage flop and its port, so the loop never sees a glitch
	assign pump_current_sel = pump_if.q; // [R14]
	assign filter_series_res_sel = res_if.q;
	assign filter_parallel_cap_sel = cap_if.q;
	assign second_pole_sel = pole_if.q;
	// the accuracy bit is passed on as written; choosing it for the filter capacitor is up to software
	assign lock_count_accuracy = acc_if.q;
	assign lock_manual_override = ovr_if.q;
	assign manual_osc_select = osc_if.q;
	assign manual_lock_code_osc_a = code_a_if.q;
	assign manual_lock_code_osc_b = code_b_if.q;
	// freerun forcing lives in the digital loop; this bank only carries the mode bit
	// limitation: nothing here stops synthesis mode being set while the digital loop still tracks
	assign synth_only_mode = syn_if.q;

	// read mux: reassemble the byte, reserved positions read as zero
	lacfg_pkg::lacfg_data_t rd_nxt; // byte for the addressed register

	always_comb begin
		rd_nxt = '0;
		case (reg_addr)
			// pump and filter byte comes back whole
			lacfg_pkg::OFF_PUMP_FILTER: begin
				rd_nxt[lacfg_pkg::POS_PUMP +: lacfg_pkg::PUMP_W] = pump_if.q;
				rd_nxt[lacfg_pkg::POS_RES +: lacfg_pkg::RES_W] = res_if.q;
				rd_nxt[lacfg_pkg::POS_CAP +: lacfg_pkg::CAP_W] = cap_if.q;
				rd_nxt[lacfg_pkg::POS_POLE] = pole_if.q;
			end
			// mode byte; reserved bits stay zero
			lacfg_pkg::OFF_MODE_LOCK: begin
				rd_nxt[lacfg_pkg::POS_SYNTH] = syn_if.q;
				rd_nxt[lacfg_pkg::POS_LOCK_ACC] = acc_if.q;
				rd_nxt[lacfg_pkg::POS_OVERRIDE] = ovr_if.q;
			end
			// oscillator select and code a
			lacfg_pkg::OFF_OSC_SEL_CODE1: begin
				rd_nxt[lacfg_pkg::POS_OSC_SEL] = osc_if.q;
				rd_nxt[lacfg_pkg::POS_CODE_A +: lacfg_pkg::CODE_W] = code_a_if.q;
			end
			// code b alone
			lacfg_pkg::OFF_OSC_CODE2: begin
				rd_nxt[lacfg_pkg::POS_CODE_B +: lacfg_pkg::CODE_W] = code_b_if.q;
			end
			default: begin
				// unmapped address reads zero
				rd_nxt = '0;
			end
		endcase
	end

	// read data register: valid only in the cycle after the strobe, zero otherwise
	// zeroing outside the answer costs nothing and makes a late sample by the master show up as zero
	lacfg_pkg::lacfg_data_t rd_data_r; // registered read answer

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_data_r <= '0;
		end else if (reg_rd_en) begin
			rd_data_r <= rd_nxt; // [R13]
		end else begin
			rd_data_r <= '0;
		end
	end

	assign reg_rd_data = rd_data_r;

	// decoded charge pump current in microamps, one cycle behind the field
	// top code gives 880, which fits ten bits; the cast drops only the unused high product bits
	logic [lacfg_pkg::PUMP_UA_W-1:0] pump_ua_r; // (code + 1) * step

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pump_ua_r <= '0;
		end else begin
			pump_ua_r <= lacfg_pkg::PUMP_UA_W'(({7'h00, pump_if.q} + 10'h001) * lacfg_pkg::PUMP_STEP_UA); // [R1]
		end
	end

	assign pump_current_ua = pump_ua_r;

	// decoded parallel capacitor in picofarads; table is not linear, so a lookup
	logic [lacfg_pkg::CAP_PF_W-1:0] cap_pf_r; // capacitor value

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cap_pf_r <= '0;
		end else begin
			case (cap_if.q)
				// 40 pF
				2'h0: begin
					cap_pf_r <= lacfg_pkg::CAP_PF_C0; // [R3]
				end
				// 80 pF, the reset choice
				2'h1: begin
					cap_pf_r <= lacfg_pkg::CAP_PF_C1;
				end
				// 140 pF
				2'h2: begin
					cap_pf_r <= lacfg_pkg::CAP_PF_C2;
				end
				// 200 pF, the largest choice
				default: begin
					cap_pf_r <= lacfg_pkg::CAP_PF_C3;
				end
			endcase
		end
	end

	assign filter_cap_pf = cap_pf_r;

	// manual lock: pick the code of the selected oscillator; only meaningful in manual mode
	// the code is always picked, even in automatic handling, so switching to manual needs no extra cycle
	// the loop must ignore the applied code while manual_lock_active is low
	// both outputs are registered so they leave the block straight from flops
	logic [lacfg_pkg::CODE_W-1:0] code_applied_r; // code sent to the chosen oscillator
	logic manual_active_r; // manual lock handling in force

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			code_applied_r <= '0;
			manual_active_r <= 1'h0;
		end else begin
			manual_active_r <= ovr_if.q; // [R7]
			if (osc_if.q) begin
				code_applied_r <= code_a_if.q; // [R8]
			end else begin
				code_applied_r <= code_b_if.q;
			end
		end
	end

	assign manual_lock_code_applied = code_applied_r;
	assign manual_lock_active = manual_active_r;

endmodule

// ==== lacfg_regs_props.sv ====
// assertions on the ports of the loop zero configuration bank
`timescale 1ns/1ps
module lacfg_regs_props (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_rd_data,
	input wire logic [2:0] pump_current_sel,
	input wire logic [1:0] filter_series_res_sel,
	input wire logic [1:0] filter_parallel_cap_sel,
	input wire logic second_pole_sel,
	input wire logic lock_count_accuracy,
	input wire logic lock_manual_override,
	input wire logic manual_osc_select,
	input wire logic [4:0] manual_lock_code_osc_a,
	input wire logic [4:0] manual_lock_code_osc_b,
	input wire logic synth_only_mode,
	input wire logic [9:0] pump_current_ua,
	input wire logic [7:0] filter_cap_pf,
	input wire logic [4:0] manual_lock_code_applied,
	input wire logic manual_lock_active
);
	// one clock domain, so clock and reset are given once
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// a write strobe aimed at one offset
	sequence s_wr(a);
		reg_wr_en && reg_addr == a;
	endsequence
	// a read strobe at the code b register
	sequence s_rd_b;
		reg_rd_en && reg_addr == 8'haf;
	endsequence
	a_pf_wr:
	assert property (s_wr(8'hac) |=> {pump_current_sel, filter_series_res_sel, filter_parallel_cap_sel,
		second_pole_sel} == $past(reg_wr_data)) else $error("pump filter write lost");
	a_mode_wr:
	assert property (s_wr(8'had) |=> {synth_only_mode, lock_count_accuracy, lock_manual_override} ==
		{$past(reg_wr_data[3]), $past(reg_wr_data[1:0])}) else $error("mode write lost");
	a_osc_wr:
	assert property (s_wr(8'hae) |=> {manual_osc_select, manual_lock_code_osc_a} == $past(reg_wr_data[5:0]))
		else $error("osc a write lost");
	a_codeb_wr:
	assert property (s_wr(8'haf) |=> manual_lock_code_osc_b == $past(reg_wr_data[4:0])) else $error("code b lost");
	// nrst in the antecedent: the edge that releases reset holds the decodes at zero
	a_pump_ua:
	assert property (nrst |=> pump_current_ua == ({7'h0, $past(pump_current_sel)} + 10'h1) * 10'h06e)
		else $error("pump current decode wrong");
	a_cap_max:
	assert property (filter_parallel_cap_sel == 2'h3 |=> filter_cap_pf == 8'hc8) else $error("cap decode wrong");
	a_code_pick:
	assert property (nrst |=> manual_lock_code_applied == ($past(manual_osc_select) ?
		$past(manual_lock_code_osc_a) : $past(manual_lock_code_osc_b))) else $error("applied code wrong");
	a_lock_act:
	assert property (nrst |=> manual_lock_active == $past(lock_manual_override)) else $error("manual flag wrong");
	a_rd_back:
	assert property (s_rd_b |=> reg_rd_data == {3'h0, $past(manual_lock_code_osc_b)}) else $error("readback wrong");
	a_rd_idle:
	assert property (!reg_rd_en |=> reg_rd_data == 8'h00) else $error("read data outside answer");
	a_field_hold:
	assert property (!reg_wr_en |=> $stable({pump_current_sel, manual_lock_code_osc_a})) else $error("field moved");
endmodule

bind lacfg_regs lacfg_regs_props u_props (.sys_clk, .nrst, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en,
	.reg_rd_data, .pump_current_sel, .filter_series_res_sel, .filter_parallel_cap_sel, .second_pole_sel,
	.lock_count_accuracy, .lock_manual_override, .manual_osc_select, .manual_lock_code_osc_a,
	.manual_lock_code_osc_b, .synth_only_mode, .pump_current_ua, .filter_cap_pf, .manual_lock_code_applied,
	.manual_lock_active);

// ==== lacfg_regs_tb.sv ====
// self-checking bench for the loop zero configuration bank
`timescale 1ns/1ps
module lacfg_regs_tb;
	logic sys_clk = 1'b0; // 125 MHz
	logic nrst = 1'b0; // active-low reset
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wr_data = 8'h00;
	logic reg_wr_en = 1'b0;
	logic reg_rd_en = 1'b0;
	logic [7:0] reg_rd_data;
	logic [2:0] pump_current_sel;
	logic [1:0] filter_series_res_sel, filter_parallel_cap_sel;
	logic second_pole_sel, lock_count_accuracy, lock_manual_override, manual_osc_select, synth_only_mode;
	logic [4:0] manual_lock_code_osc_a, manual_lock_code_osc_b, manual_lock_code_applied;
	logic [9:0] pump_current_ua;
	logic [7:0] filter_cap_pf;
	logic manual_lock_active;
	int err_total = 0;
	int compares = 0;
	logic [31:0] rng_r = 32'h0000_6177; // fixed seed
	logic [7:0] m [4]; // expected register images
	// writable bits per register; reserved bits are kept zero by software
	localparam logic [3:0][7:0] MASK = {8'h1f, 8'h3f, 8'h0b, 8'hff};
	localparam logic [3:0][7:0] RSTV = {8'h00, 8'h2b, 8'h02, 8'h8b};
	always #4 sys_clk = ~sys_clk;
	lacfg_regs u_dut (.sys_clk, .nrst, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en, .reg_rd_data,
		.pump_current_sel, .filter_series_res_sel, .filter_parallel_cap_sel, .second_pole_sel,
		.lock_count_accuracy, .lock_manual_override, .manual_osc_select, .manual_lock_code_osc_a,
		.manual_lock_code_osc_b, .synth_only_mode, .pump_current_ua, .filter_cap_pf,
		.manual_lock_code_applied, .manual_lock_active);
	// capacitance in pF for a cap code
	function automatic logic [7:0] pf(input logic [1:0] c);
		case (c)
			2'h0: return 8'h28;
			2'h1: return 8'h50;
			2'h2: return 8'h8c;
			default: return 8'hc8;
		endcase
	endfunction
	// xorshift step, repeatable from the seed
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic end_sim();
		if (err_total == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one bus cycle, driven just after the edge
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr_en <= w;
		reg_rd_en <= r;
		reg_addr <= a;
		reg_wr_data <= d;
	endtask
	// read, then look at the answer in its single cycle
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		#1 chk(reg_rd_data, e);
	endtask
	task automatic rd_all();
		for (int i = 0; i < 4; i++)
			rd_chk(8'hac + 8'(i), m[i]);
	endtask
	// every field and decode against the register images
	task automatic chk_all();
		chk({pump_current_sel, filter_series_res_sel, filter_parallel_cap_sel, second_pole_sel}, m[0]);
		chk({synth_only_mode, 1'b0, lock_count_accuracy, lock_manual_override}, m[1]);
		chk({manual_osc_select, manual_lock_code_osc_a}, m[2]);
		chk(manual_lock_code_osc_b, m[3]);
		chk(pump_current_ua, (16'(m[0][7:5]) + 16'h1) * 16'h006e);
		chk(filter_cap_pf, pf(m[0][2:1]));
		chk(manual_lock_code_applied, m[2][5] ? m[2][4:0] : m[3][4:0]);
		chk(manual_lock_active, m[1][0]);
	endtask
	// reset is held five cycles; the images go back to defaults
	task automatic do_reset();
		nrst <= 1'b0;
		for (int i = 0; i < 4; i++)
			m[i] = RSTV[i];
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		#1 chk_all();
		rd_all();
	endtask
	initial begin
		logic [1:0] k;
		logic [7:0] d;
		do_reset();
		// write then read back at once; first pass sets every writable bit of one register, second clears one register
		for (int j = 0; j < 60; j++) begin
			rng_r = xs(rng_r);
			k = rng_r[9:8];
			// reserved bits stay zero; the accuracy bit is drawn freely, as boards with either capacitor size exist
			// the freerun forcing that goes with synthesis mode belongs to the digital loop outside this bank
			d = (j == 0) ? MASK[k] : (j == 1) ? 8'h00 : rng_r[7:0] & MASK[k];
			m[k] = d;
			bus(1'b1, 1'b0, 8'hac + 8'(k), d);
			rd_chk(8'hac + 8'(k), d);
			chk_all();
		end
		// unmapped places leave the bank alone and read zero
		bus(1'b1, 1'b0, 8'hb0, rng_r[15:8]);
		rd_chk(8'hb0, 8'h00);
		rd_chk(8'hab, 8'h00);
		chk_all();
		// mid-run reset is launched on a rising edge like every other input
		@(posedge sys_clk);
		do_reset();
		end_sim();
	end
endmodule
